// File: rtl/meb_top.sv
`timescale 1ns/1ps

module meb_sync #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // Three stages; a bit changes once stages two and three agree
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q_out <= '0;
        end else begin
            s1 <= d_in;
            s2 <= s1;
            s3 <= s2;
            q_out <= (s2 & s3) | (q_out & (s2 | s3));
        end
    end
endmodule : meb_sync

module meb_top (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Mode straps
    input wire logic processor_mode_pin_in,
    input wire logic bus_width_pin_in,
    // Core transfer request
    input wire logic xfer_req_in,
    input wire logic xfer_wr_in,
    input wire logic xfer_hi_in,
    input wire logic [23:0] xfer_addr_in,
    input wire logic [15:0] xfer_wdata_in,
    output logic xfer_busy_out,
    output logic xfer_done_out,
    output logic [15:0] xfer_rdata_out,
    // Core port settings
    input wire logic cfg_we_in,
    input wire logic [2:0] cfg_sel_in,
    input wire logic [7:0] cfg_data_in,
    input wire logic hold_acknowledge_in,
    output logic [27:0] pin_read_out,
    output logic expansion_out,
    // Bus enable
    output logic enable_n_out,
    // Ports
    input wire logic [7:0] port_zero_in,
    output logic [7:0] port_zero_out,
    output logic [7:0] port_zero_oe_out,
    input wire logic [7:0] port_one_in,
    output logic [7:0] port_one_out,
    output logic [7:0] port_one_oe_out,
    input wire logic [7:0] port_two_in,
    output logic [7:0] port_two_out,
    output logic [7:0] port_two_oe_out,
    input wire logic [3:0] port_three_in,
    output logic [3:0] port_three_out,
    output logic [3:0] port_three_oe_out
);
    logic [1:0] rst_pipe;
    logic rst_n;
    logic [1:0] straps;
    logic exp_mode;
    logic bus8;
    logic [27:0] pins_q;
    logic [7:0] port_data [4];
    logic [7:0] port_dir [4];
    meb_pkg::meb_state_e state;
    logic [2:0] cnt;
    logic [23:0] cur_addr;
    logic [15:0] cur_wdata;
    logic wr;
    logic hi;
    logic dph;
    logic act;

    // Reset release through two flops
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    meb_sync #(.W(2)) u_strap_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .d_in({bus_width_pin_in, processor_mode_pin_in}),
        .q_out(straps)
    );
    assign exp_mode = straps[0];
    assign bus8 = straps[1];

    meb_sync #(.W(28)) u_pin_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .d_in({port_three_in, port_two_in, port_one_in, port_zero_in}),
        .q_out(pins_q)
    );

    // Port data and direction settings
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                port_data[i] <= meb_pkg::DATA_RST;
                port_dir[i] <= meb_pkg::DIR_RST;
            end
        end else if (cfg_we_in) begin
            if (cfg_sel_in[meb_pkg::SEL_DIR_BIT]) begin
                port_dir[cfg_sel_in[1:0]] <= cfg_data_in;
            end else begin
                port_data[cfg_sel_in[1:0]] <= cfg_data_in;
            end
        end
    end

    // Bus cycle sequencer
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= meb_pkg::MEB_IDLE;
            cnt <= 3'h0;
            cur_addr <= 24'h000000;
            cur_wdata <= 16'h0000;
            wr <= 1'b0;
            hi <= 1'b0;
        end else begin
            case (state)
                meb_pkg::MEB_IDLE: begin
                    if (exp_mode && xfer_req_in) begin
                        state <= meb_pkg::MEB_ADDR;
                        cnt <= 3'h0;
                        cur_addr <= xfer_addr_in;
                        cur_wdata <= xfer_wdata_in;
                        wr <= xfer_wr_in;
                        hi <= xfer_hi_in;
                    end
                end
                meb_pkg::MEB_ADDR: begin
                    if (cnt == meb_pkg::ADDR_LAST) begin
                        state <= meb_pkg::MEB_DATA;
                        cnt <= 3'h0;
                    end else begin
                        cnt <= cnt + 3'h1;
                    end
                end
                meb_pkg::MEB_DATA: begin
                    if (cnt == meb_pkg::DATA_LAST) begin
                        state <= meb_pkg::MEB_DONE;
                        cnt <= 3'h0;
                    end else begin
                        cnt <= cnt + 3'h1;
                    end
                end
                meb_pkg::MEB_DONE: begin
                    state <= meb_pkg::MEB_IDLE;
                end
                default: begin
                    state <= meb_pkg::MEB_IDLE;
                end
            endcase
        end
    end

    assign dph = (state == meb_pkg::MEB_DATA);
    assign act = (state != meb_pkg::MEB_IDLE);

    // Core side answers
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            xfer_busy_out <= 1'b0;
            xfer_done_out <= 1'b0;
            xfer_rdata_out <= 16'h0000;
            pin_read_out <= 28'h0000000;
            expansion_out <= 1'b0;
        end else begin
            xfer_busy_out <= (state != meb_pkg::MEB_DONE) && (act || (exp_mode && xfer_req_in));
            xfer_done_out <= dph && (cnt == meb_pkg::DATA_LAST);
            if (dph && (cnt == meb_pkg::DATA_LAST) && !wr) begin
                xfer_rdata_out <= {bus8 ? 8'h00 : pins_q[15:8], pins_q[23:16]};
            end
            pin_read_out <= pins_q;
            expansion_out <= exp_mode;
        end
    end

    // Pin drivers
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            enable_n_out <= 1'b1;
            port_zero_out <= 8'h00;
            port_zero_oe_out <= 8'h00;
            port_one_out <= 8'h00;
            port_one_oe_out <= 8'h00;
            port_two_out <= 8'h00;
            port_two_oe_out <= 8'h00;
            port_three_out <= 4'h0;
            port_three_oe_out <= 4'h0;
        end else if (exp_mode) begin
            enable_n_out <= !dph;
            port_zero_out <= cur_addr[7:0];
            port_zero_oe_out <= 8'hff;
            if (!bus8 && dph) begin
                port_one_out <= cur_wdata[15:8];
                port_one_oe_out <= {8{wr}};
            end else begin
                port_one_out <= cur_addr[15:8];
                port_one_oe_out <= 8'hff;
            end
            if (dph) begin
                port_two_out <= cur_wdata[7:0];
                port_two_oe_out <= {8{wr}};
            end else begin
                port_two_out <= cur_addr[23:16];
                port_two_oe_out <= 8'hff;
            end
            port_three_out[meb_pkg::P3_RW] <= !(wr && act);
            port_three_out[meb_pkg::P3_BHE] <= !(!bus8 && hi && act);
            port_three_out[meb_pkg::P3_ALE] <= (state == meb_pkg::MEB_ADDR) && (cnt == 3'h0);
            port_three_out[meb_pkg::P3_HOLD_ACKNOWLEDGE] <= hold_acknowledge_in;
            port_three_oe_out <= 4'hf;
        end else begin
            enable_n_out <= 1'b1;
            port_zero_out <= port_data[0];
            port_zero_oe_out <= port_dir[0];
            port_one_out <= port_data[1];
            port_one_oe_out <= port_dir[1];
            port_two_out <= port_data[2];
            port_two_oe_out <= port_dir[2];
            port_three_out <= port_data[3][3:0];
            port_three_oe_out <= port_dir[3][3:0];
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    sequence start_s;
        state == meb_pkg::MEB_IDLE && exp_mode && xfer_req_in;
    endsequence
    sequence phases_s;
        (state == meb_pkg::MEB_ADDR) [*2] ##1 (state == meb_pkg::MEB_DATA) [*6]
            ##1 (state == meb_pkg::MEB_DONE);
    endsequence

    bus_phases_a: assert property (start_s |=> phases_s)
        else $error("bus phase order wrong");
    ale_strobe_a: assert property (start_s |=> ##1 port_three_out[meb_pkg::P3_ALE]
            && enable_n_out ##1 !port_three_out[meb_pkg::P3_ALE])
        else $error("latch strobe not pulsed in address phase");
    done_enable_a: assert property (xfer_done_out |-> $past(!enable_n_out, 2))
        else $error("transfer done without enable low");
    reset_input_a: assert property ($past(!rst_n) |-> port_zero_oe_out == 8'h00
            && port_one_oe_out == 8'h00 && port_two_oe_out == 8'h00)
        else $error("pins not inputs after reset");
    mode_follow_a: assert property ((straps[0] != $past(straps[0])) |=>
            expansion_out == $past(straps[0]))
        else $error("mode output did not follow strap");
    addr_low_a: assert property (exp_mode && $past(exp_mode) |=> port_zero_out
            == $past(cur_addr[7:0]) && port_zero_oe_out == 8'hff)
        else $error("port zero not driving address");
    byte_addr_a: assert property (exp_mode && bus8 |=> port_one_oe_out == 8'hff
            && port_one_out == $past(cur_addr[15:8]))
        else $error("port one carried data on 8-bit bus");
    wide_data_a: assert property (exp_mode && !bus8 && dph |=> !enable_n_out
            && port_one_oe_out == {8{$past(wr)}})
        else $error("port one data phase wrong");
    low_data_a: assert property (exp_mode && dph && wr |=> port_two_oe_out == 8'hff
            && port_two_out == $past(cur_wdata[7:0]))
        else $error("port two write data wrong");
    strobes_a: assert property (exp_mode |=> port_three_oe_out == 4'hf)
        else $error("port three strobes not driven");
    single_dir_a: assert property (!exp_mode |=>
            port_one_oe_out == $past(port_dir[1]) && port_zero_oe_out == $past(port_dir[0]))
        else $error("single-chip direction not applied");
endmodule : meb_top

// File: shared/meb_pkg.sv
package meb_pkg;
    // Timing
    localparam int CLK_NS = 10;
    localparam int ADDR_NS = 20;
    localparam int DATA_NS = 60;
    localparam int ADDR_CYC = (ADDR_NS + CLK_NS - 1) / CLK_NS;
    localparam int DATA_CYC = (DATA_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0] ADDR_LAST = 3'(ADDR_CYC - 1);
    localparam logic [2:0] DATA_LAST = 3'(DATA_CYC - 1);

    // Port setting select: bit 2 picks direction, bits 1:0 the port
    localparam int SEL_DIR_BIT = 2;

    // Reset values
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    // Port three strobe positions in expansion modes
    localparam int P3_RW = 0;
    localparam int P3_BHE = 1;
    localparam int P3_ALE = 2;
    localparam int P3_HOLD_ACKNOWLEDGE = 3;

    typedef enum logic [1:0] {
        MEB_IDLE = 2'b00,
        MEB_ADDR = 2'b01,
        MEB_DATA = 2'b10,
        MEB_DONE = 2'b11
    } meb_state_e;
endpackage : meb_pkg

// File: test/meb_ext_mem.sv
`timescale 1ns/1ps

module meb_ext_mem (
    // Clock
    input wire logic clk_in,
    // Bus strobes
    input wire logic enable_n_in,
    input wire logic ale_in,
    input wire logic rw_in,
    input wire logic [15:0] addr_in,
    // Data towards the block
    output logic [15:0] data_out
);
    logic [15:0] addr;
    logic [15:0] last;
    logic drive;

    // Address captured on the latch strobe
    always_ff @(posedge clk_in) begin
        if (ale_in) begin
            addr <= addr_in;
        end
    end

    // Drives only while enable is low on reads; released lines show the inverse
    assign drive = !enable_n_in && rw_in;
    assign data_out = drive ? ~addr : ~last;
    always_ff @(posedge clk_in) begin
        if (drive) begin
            last <= ~addr;
        end
    end
endmodule : meb_ext_mem

// File: test/tb_multiplexed_external_bus_ports.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end

module tb_multiplexed_external_bus_ports;
    logic clk_in = 0, rst_b_in = 0, mode = 0, width = 0, req = 0, wr = 0, hi = 0;
    logic cfg_we = 0, hold_acknowledge = 0;
    logic [2:0] cfg_sel = 3'h0;
    logic [7:0] cfg_data = 8'h00, ext_pat = 8'h3c;
    logic [23:0] addr = 24'h000000;
    logic [15:0] wdata = 16'h0000, rdata, mem_data;
    logic busy, done, expn, en_n;
    logic [27:0] pin_read;
    logic [7:0] p0_i, p0_o, p0_oe, p1_i, p1_o, p1_oe, p2_i, p2_o, p2_oe;
    logic [3:0] p3_i, p3_o, p3_oe;
    int fails = 0, num_checks = 0;

    always #5 clk_in = ~clk_in;

    assign p0_i = (p0_oe & p0_o) | (~p0_oe & ext_pat);
    assign p1_i = (p1_oe & p1_o) | (~p1_oe & (expn ? mem_data[15:8] : ext_pat));
    assign p2_i = (p2_oe & p2_o) | (~p2_oe & (expn ? mem_data[7:0] : ext_pat));
    assign p3_i = (p3_oe & p3_o) | (~p3_oe & ext_pat[3:0]);

    meb_top dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .processor_mode_pin_in(mode),
        .bus_width_pin_in(width), .xfer_req_in(req), .xfer_wr_in(wr), .xfer_hi_in(hi),
        .xfer_addr_in(addr), .xfer_wdata_in(wdata), .xfer_busy_out(busy),
        .xfer_done_out(done), .xfer_rdata_out(rdata), .cfg_we_in(cfg_we),
        .cfg_sel_in(cfg_sel), .cfg_data_in(cfg_data), .hold_acknowledge_in(hold_acknowledge),
        .pin_read_out(pin_read), .expansion_out(expn), .enable_n_out(en_n),
        .port_zero_in(p0_i), .port_zero_out(p0_o), .port_zero_oe_out(p0_oe),
        .port_one_in(p1_i), .port_one_out(p1_o), .port_one_oe_out(p1_oe),
        .port_two_in(p2_i), .port_two_out(p2_o), .port_two_oe_out(p2_oe),
        .port_three_in(p3_i), .port_three_out(p3_o), .port_three_oe_out(p3_oe));

    meb_ext_mem mem (.clk_in(clk_in), .enable_n_in(en_n),
        .ale_in(p3_o[meb_pkg::P3_ALE]), .rw_in(p3_o[meb_pkg::P3_RW]),
        .addr_in({p1_o, p0_o}), .data_out(mem_data));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick

    task automatic cfg(input logic [2:0] s, input logic [7:0] d);
        @(posedge clk_in);
        cfg_we <= 1'b1;
        cfg_sel <= s;
        cfg_data <= d;
        @(posedge clk_in);
        cfg_we <= 1'b0;
    endtask : cfg

    task automatic start(input logic w, input logic h, input logic [23:0] a,
                         input logic [15:0] d);
        @(posedge clk_in);
        req <= 1'b1;
        wr <= w;
        hi <= h;
        addr <= a;
        wdata <= d;
        @(posedge clk_in);
        req <= 1'b0;
        #1;
    endtask : start

    task automatic wait_for(input int sig);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 12; i++) begin
            hit = (sig == 0) ? (p3_o[meb_pkg::P3_ALE] === 1'b1)
                : (sig == 1) ? (en_n === 1'b0) : (done === 1'b1);
            if (hit) break;
            tick(1);
        end
        `CHK("wait", 1'b1, hit)
    endtask : wait_for

    task automatic t_reset;
        `CHK("oe", 28'h0, {p3_oe, p2_oe, p1_oe, p0_oe})
        `CHK("en_n", 1'b1, en_n)
    endtask : t_reset

    task automatic t_single;
        cfg(3'h4, 8'hff);
        cfg(3'h0, 8'h5a);
        cfg(3'h5, 8'h0f);
        cfg(3'h1, 8'ha5);
        cfg(3'h7, 8'h0f);
        cfg(3'h3, 8'h09);
        tick(2);
        `CHK("expn", 1'b0, expn)
        `CHK("p0", 16'hff5a, {p0_oe, p0_o})
        `CHK("p1", 12'h0f5, {p1_oe, p1_o[3:0]})
        `CHK("p3", 8'hf9, {p3_oe, p3_o})
        tick(4);
        `CHK("pin p2", 8'h3c, pin_read[23:16])
        start(1'b0, 1'b0, 24'h000001, 16'h0000);
        tick(2);
        `CHK("busy", 1'b0, busy)
        `CHK("en_n", 1'b1, en_n)
    endtask : t_single

    task automatic t_write16;
        @(posedge clk_in);
        hold_acknowledge <= 1'b1;
        start(1'b1, 1'b1, 24'habcdef, 16'h1234);
        `CHK("expn", 1'b1, expn)
        wait_for(0);
        `CHK("busy", 1'b1, busy)
        `CHK("addr", 24'habcdef, {p2_o, p1_o, p0_o})
        `CHK("strobes", 4'b1100, {en_n, p3_o[3], p3_o[1:0]})
        tick(1);
        `CHK("ale", 1'b0, p3_o[meb_pkg::P3_ALE])
        wait_for(1);
        `CHK("wdata", 16'h1234, {p1_o, p2_o})
        `CHK("w oe", 16'hffff, {p1_oe, p2_oe})
        wait_for(2);
        tick(1);
        `CHK("addr back", 9'h1ab, {en_n, p2_o})
        @(posedge clk_in);
        hold_acknowledge <= 1'b0;
    endtask : t_write16

    task automatic t_read(input logic [23:0] a, input logic [15:0] e, input logic w8);
        start(1'b0, w8, a, 16'h0000);
        wait_for(0);
        `CHK("rw bhe hold_acknowledge", 3'b011, {p3_o[3], p3_o[1:0]})
        wait_for(1);
        `CHK("p2 oe", 8'h00, p2_oe)
        `CHK("p1", w8 ? {8'hff, a[15:8]} : 16'h0000, {p1_oe, p1_o & {8{w8}}})
        wait_for(2);
        `CHK("rdata", e, rdata)
    endtask : t_read

    task automatic summarize;
        if (fails == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    initial begin
        #200000;
        fails++;
        summarize();
    end

    initial begin
        tick(3);
        t_reset();
        @(posedge clk_in);
        rst_b_in <= 1'b1;
        tick(8);
        t_single();
        @(posedge clk_in);
        mode <= 1'b1;
        tick(8);
        t_write16();
        t_read(24'h123456, 16'hcba9, 1'b0);
        @(posedge clk_in);
        width <= 1'b1;
        tick(6);
        t_read(24'h00a5c3, 16'h003c, 1'b1);
        summarize();
    end
endmodule : tb_multiplexed_external_bus_ports
